// *** design/flash_table_pkg.sv ***
`default_nettype none
package flash_table_pkg;

    // ----------------------------------------------------------------
    // register addresses in the special function space
    // ----------------------------------------------------------------
    localparam logic [11:0] MEMORY_CONTROL_ADDR = 12'hfa6;
    localparam logic [11:0] UNLOCK_SEQUENCE_ADDR = 12'hfa7;
    localparam logic [11:0] TABLE_LATCH_ADDR = 12'hff5;
    localparam logic [11:0] POINTER_LOW_ADDR = 12'hff6;
    localparam logic [11:0] POINTER_HIGH_ADDR = 12'hff7;
    localparam logic [11:0] POINTER_UPPER_ADDR = 12'hff8;

    // ----------------------------------------------------------------
    // values, widths and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam logic [7:0] MEMORY_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TABLE_LATCH_RESET = 8'h00;
    localparam logic [21:0] POINTER_RESET = 22'h000000;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam int PTR_W = 22;
    localparam int HOLD_COUNT = 8;
    localparam int HOLD_IDX_W = 3;
    localparam int ERASE_LOW_BITS = 6;
    localparam int UPPER_BITS = 6;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_TIME_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 18;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PTR_KEEP = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC = 2'b11
    } ptr_mode_t;

    typedef enum logic [1:0] {
        UNL_IDLE = 2'b00,
        UNL_FIRST = 2'b01,
        UNL_ARMED = 2'b11
    } unlock_state_t;

    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_RUN = 2'b01,
        CYC_DONE = 2'b11
    } cycle_state_t;

    typedef struct packed {
        logic program_memory_select;
        logic config_space_select;
        logic unused;
        logic row_erase_enable;
        logic write_error_flag;
        logic write_enable_bit;
        logic write_start;
        logic read_start;
    } memory_control_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        ptr_mode_t mode;
    } table_req_t;

    typedef struct packed {
        logic erase;
        logic cfg_space;
        logic [21:0] addr;
        logic [63:0] data;
    } prog_cmd_t;

endpackage : flash_table_pkg
`default_nettype wire

// *** design/program_flash_table_access.sv ***
// How it works
// - one-byte reads, 8-byte programming, 64-byte erase
// - only row erase, never bulk erase
// - fetches stall until the timer ends erase or write of program or configuration space
// - any value storable; invalid fetches run as no-op
// - all bytes pass the single table latch
// - bytewise table access, any byte alignment
// - table write fills holding register at pointer bits 2:0
// - timed write programs block at pointer bits 21:3
// - row erase uses pointer bits 21:6 only
// - table read uses all 22 pointer bits
// - four pointer modes change only the low 21 bits
// - pointer bit 21 selects id and configuration space
// - unlock register stores nothing, reads zero
// - memory select: set program memory, clear data eeprom
// - configuration select overrides memory select for erase and write cycles
// - row erase enable turns next start into erase, clears after
// - write enable clear at power-up, gates erase and write cycles, not read start
// - reset mid-cycle sets error flag, keeps select bits
// - write start set-only by software, cleared at finish
// - finish sets sticky write-done flag until software clears
// - read start set-only, one cycle, refused for program memory
// - erase or block write stalls the core about 2 ms
`default_nettype none
module program_flash_table_access
    import flash_table_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_TIME_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire table_req_t table_req,
    output logic table_done,
    output logic flash_rd_en,
    output logic [21:0] flash_rd_addr,
    input wire logic [7:0] flash_rd_data,
    output logic prog_start,
    output prog_cmd_t prog_cmd,
    output logic eeprom_wr_start,
    output logic eeprom_rd_start,
    output logic fetch_stall,
    input wire logic [15:0] fetch_word,
    input wire logic fetch_invalid,
    output logic [15:0] exec_word,
    input wire logic master_clear_pin_n,
    input wire logic watchdog_reset,
    output logic write_done_irq_flag,
    input wire logic write_done_irq_clear
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // no carry or borrow reaches bit 21
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic dec);
        logic [20:0] low;
        low = dec ? (p[20:0] - 21'h000001) : (p[20:0] + 21'h000001);
        return {p[21], low};
    endfunction : ptr_step

    function automatic logic [21:0] ptr_effective(input logic [21:0] p, input ptr_mode_t m);
        return (m == PTR_PRE_INC) ? ptr_step(p, 1'b0) : p;
    endfunction : ptr_effective

    function automatic logic [21:0] ptr_after(input logic [21:0] p, input ptr_mode_t m);
        logic [21:0] r;
        r = p;
        case (m)
            PTR_POST_INC: r = ptr_step(p, 1'b0);
            PTR_POST_DEC: r = ptr_step(p, 1'b1);
            PTR_PRE_INC: r = ptr_step(p, 1'b0);
            default: r = p;
        endcase
        return r;
    endfunction : ptr_after

    // ----------------------------------------------------------------
    // reset sources
    // ----------------------------------------------------------------
    logic master_clear_pin_meta_q;
    logic master_clear_pin_sync_q;
    logic soft_reset;

    // asynchronous pin, two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_clear_pin_meta_q <= 1'b1;
            master_clear_pin_sync_q <= 1'b1;
        end else begin
            master_clear_pin_meta_q <= master_clear_pin_n;
            master_clear_pin_sync_q <= master_clear_pin_meta_q;
        end
    end

    assign soft_reset = !master_clear_pin_sync_q || watchdog_reset;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    memory_control_t ctrl_q;
    unlock_state_t unlock_q;
    cycle_state_t cyc_q;
    logic [TIMER_W-1:0] timer_q;
    logic [21:0] ptr_q;
    logic [7:0] latch_q;
    logic [7:0] hold_q [HOLD_COUNT];
    logic [7:0] sfr_rdata_q;
    logic rd_pend_q;
    logic table_done_q;
    logic flash_rd_en_q;
    logic [21:0] flash_rd_addr_q;
    logic prog_start_q;
    prog_cmd_t prog_cmd_q;
    logic eeprom_wr_start_q;
    logic eeprom_rd_start_q;
    logic stall_q;
    logic [15:0] exec_word_q;
    logic irq_flag_q;
    logic wr_ctrl;
    logic wr_unlock;
    logic start_req;
    logic start_ok;
    logic cycle_end;
    logic table_go;
    logic [21:0] ptr_eff;
    memory_control_t ctrl_wdata;

    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == MEMORY_CONTROL_ADDR);
    assign wr_unlock = sfr_req.wr && (sfr_req.addr == UNLOCK_SEQUENCE_ADDR);
    assign ctrl_wdata = memory_control_t'(sfr_req.wdata);
    // start counts only right after the unlock pair
    assign start_req = wr_ctrl && ctrl_wdata.write_start && !ctrl_q.write_start
        && (unlock_q == UNL_ARMED) && (cyc_q == CYC_IDLE);
    assign start_ok = start_req && ctrl_q.write_enable_bit;
    assign cycle_end = (cyc_q == CYC_RUN) && (timer_q == TIMER_W'(PROG_CYCLES - 1));
    // stalled core: table requests dropped
    assign table_go = table_req.valid && !stall_q;
    assign ptr_eff = ptr_effective(ptr_q, table_req.mode);

    // ----------------------------------------------------------------
    // unlock sequence
    // ----------------------------------------------------------------
    // any other register write breaks the pair
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_q <= UNL_IDLE;
        end else if (soft_reset) begin
            unlock_q <= UNL_IDLE;
        end else if (wr_unlock) begin
            case (unlock_q)
                UNL_IDLE: unlock_q <= (sfr_req.wdata == UNLOCK_FIRST) ? UNL_FIRST : UNL_IDLE;
                UNL_FIRST: unlock_q <= (sfr_req.wdata == UNLOCK_SECOND) ? UNL_ARMED : UNL_IDLE;
                default: unlock_q <= UNL_IDLE;
            endcase
        end else if (sfr_req.wr) begin
            unlock_q <= UNL_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // memory control register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= memory_control_t'(MEMORY_CONTROL_RESET);
        end else if (soft_reset) begin
            // selects survive to trace the failed cycle
            ctrl_q.row_erase_enable <= 1'b0;
            ctrl_q.write_enable_bit <= 1'b0;
            ctrl_q.write_start <= 1'b0;
            ctrl_q.read_start <= 1'b0;
            ctrl_q.unused <= 1'b0;
            if (cyc_q != CYC_IDLE) begin
                ctrl_q.write_error_flag <= 1'b1;
            end
        end else begin
            if (wr_ctrl && (cyc_q == CYC_IDLE)) begin
                ctrl_q.program_memory_select <= ctrl_wdata.program_memory_select;
                ctrl_q.config_space_select <= ctrl_wdata.config_space_select;
                ctrl_q.row_erase_enable <= ctrl_wdata.row_erase_enable;
                ctrl_q.write_error_flag <= ctrl_wdata.write_error_flag;
                ctrl_q.write_enable_bit <= ctrl_wdata.write_enable_bit;
            end
            if (start_ok) begin
                ctrl_q.write_start <= 1'b1;
            end else if (cycle_end) begin
                ctrl_q.write_start <= 1'b0;
                if (prog_cmd_q.erase) begin
                    ctrl_q.row_erase_enable <= 1'b0;
                end
            end
            // read start is refused while program memory is selected
            if (wr_ctrl && ctrl_wdata.read_start && !ctrl_q.read_start
                && !ctrl_wdata.program_memory_select && !ctrl_q.program_memory_select) begin
                ctrl_q.read_start <= 1'b1;
            end else begin
                ctrl_q.read_start <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // self-timed cycle
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_q <= CYC_IDLE;
            timer_q <= '0;
        end else if (soft_reset) begin
            cyc_q <= CYC_IDLE;
            timer_q <= '0;
        end else begin
            case (cyc_q)
                CYC_IDLE: begin
                    timer_q <= '0;
                    if (start_ok) begin
                        cyc_q <= CYC_RUN;
                    end
                end
                CYC_RUN: begin
                    timer_q <= timer_q + TIMER_W'(1);
                    if (cycle_end) begin
                        cyc_q <= CYC_DONE;
                    end
                end
                default: begin
                    cyc_q <= CYC_IDLE;
                    timer_q <= '0;
                end
            endcase
        end
    end

    // eeprom cycles leave fetches running
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stall_q <= 1'b0;
        end else if (soft_reset || cycle_end) begin
            stall_q <= 1'b0;
        end else if (start_ok && (ctrl_q.program_memory_select || ctrl_q.config_space_select)) begin
            stall_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // array commands
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_start_q <= 1'b0;
            eeprom_wr_start_q <= 1'b0;
            prog_cmd_q <= '0;
        end else begin
            prog_start_q <= 1'b0;
            eeprom_wr_start_q <= 1'b0;
            if (start_ok && !soft_reset) begin
                if (ctrl_q.config_space_select) begin
                    prog_start_q <= 1'b1;
                end else if (ctrl_q.program_memory_select) begin
                    prog_start_q <= 1'b1;
                end else begin
                    eeprom_wr_start_q <= 1'b1;
                end
                prog_cmd_q.cfg_space <= ctrl_q.config_space_select;
                prog_cmd_q.erase <= ctrl_q.row_erase_enable;
                if (ctrl_q.row_erase_enable) begin
                    // only row erase exists
                    prog_cmd_q.addr <= {ptr_q[21:ERASE_LOW_BITS],
                        {ERASE_LOW_BITS{1'b0}}};
                end else begin
                    prog_cmd_q.addr <= {ptr_q[21:HOLD_IDX_W], {HOLD_IDX_W{1'b0}}};
                end
                for (int i = 0; i < HOLD_COUNT; i++) begin
                    prog_cmd_q.data[i*8 +: 8] <= hold_q[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            eeprom_rd_start_q <= 1'b0;
        end else begin
            eeprom_rd_start_q <= wr_ctrl && ctrl_wdata.read_start && !ctrl_q.read_start
                && !ctrl_wdata.program_memory_select && !ctrl_q.program_memory_select
                && !soft_reset;
        end
    end

    // ----------------------------------------------------------------
    // table pointer
    // ----------------------------------------------------------------
    // a register write beats the automatic update
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= POINTER_RESET;
        end else if (soft_reset) begin
            ptr_q <= POINTER_RESET;
        end else if (sfr_req.wr && (sfr_req.addr == POINTER_LOW_ADDR)) begin
            ptr_q[7:0] <= sfr_req.wdata;
        end else if (sfr_req.wr && (sfr_req.addr == POINTER_HIGH_ADDR)) begin
            ptr_q[15:8] <= sfr_req.wdata;
        end else if (sfr_req.wr && (sfr_req.addr == POINTER_UPPER_ADDR)) begin
            ptr_q[21:16] <= sfr_req.wdata[UPPER_BITS-1:0];
        end else if (table_go) begin
            ptr_q <= ptr_after(ptr_q, table_req.mode);
        end
    end

    // ----------------------------------------------------------------
    // table read path
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flash_rd_en_q <= 1'b0;
            flash_rd_addr_q <= POINTER_RESET;
            rd_pend_q <= 1'b0;
        end else begin
            flash_rd_en_q <= table_go && !table_req.write && !soft_reset;
            rd_pend_q <= table_go && !table_req.write && !soft_reset;
            if (table_go && !table_req.write) begin
                flash_rd_addr_q <= ptr_eff;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            table_done_q <= 1'b0;
        end else begin
            table_done_q <= (table_go && table_req.write) || rd_pend_q;
        end
    end

    // ----------------------------------------------------------------
    // latch and holding registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_q <= TABLE_LATCH_RESET;
        end else if (soft_reset) begin
            latch_q <= TABLE_LATCH_RESET;
        end else if (sfr_req.wr && (sfr_req.addr == TABLE_LATCH_ADDR)) begin
            latch_q <= sfr_req.wdata;
        end else if (rd_pend_q) begin
            latch_q <= flash_rd_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < HOLD_COUNT; i++) begin
                hold_q[i] <= 8'h00;
            end
        end else if (table_go && table_req.write && !soft_reset) begin
            hold_q[ptr_eff[HOLD_IDX_W-1:0]] <= latch_q;
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata_q <= 8'h00;
        end else if (!sfr_req.rd) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_req.addr == MEMORY_CONTROL_ADDR) begin
            sfr_rdata_q <= {ctrl_q[7:6], 1'b0, ctrl_q[4:0]};
        end else if (sfr_req.addr == UNLOCK_SEQUENCE_ADDR) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_req.addr == TABLE_LATCH_ADDR) begin
            sfr_rdata_q <= latch_q;
        end else if (sfr_req.addr == POINTER_LOW_ADDR) begin
            sfr_rdata_q <= ptr_q[7:0];
        end else if (sfr_req.addr == POINTER_HIGH_ADDR) begin
            sfr_rdata_q <= ptr_q[15:8];
        end else if (sfr_req.addr == POINTER_UPPER_ADDR) begin
            sfr_rdata_q <= {2'b00, ptr_q[21:16]};
        end else begin
            sfr_rdata_q <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // completion flag and fetch filter
    // ----------------------------------------------------------------
    // set beats clear in one cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flag_q <= 1'b0;
        end else if (cycle_end && !soft_reset) begin
            irq_flag_q <= 1'b1;
        end else if (write_done_irq_clear) begin
            irq_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            exec_word_q <= NOP_WORD;
        end else begin
            exec_word_q <= fetch_invalid ? NOP_WORD : fetch_word;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign sfr_rdata = sfr_rdata_q;
    assign table_done = table_done_q;
    assign flash_rd_en = flash_rd_en_q;
    assign flash_rd_addr = flash_rd_addr_q;
    assign prog_start = prog_start_q;
    assign prog_cmd = prog_cmd_q;
    assign eeprom_wr_start = eeprom_wr_start_q;
    assign eeprom_rd_start = eeprom_rd_start_q;
    assign fetch_stall = stall_q;
    assign exec_word = exec_word_q;
    assign write_done_irq_flag = irq_flag_q;

endmodule : program_flash_table_access
`default_nettype wire

// *** verification/flash_table_asserts.sv ***
`default_nettype none
module flash_table_checker
    import flash_table_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire table_req_t table_req,
    input wire logic table_done,
    input wire logic flash_rd_en,
    input wire logic prog_start,
    input wire prog_cmd_t prog_cmd,
    input wire logic fetch_stall,
    input wire logic fetch_invalid,
    input wire logic [15:0] exec_word,
    input wire logic write_done_irq_flag,
    input wire logic write_done_irq_clear
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_read_timing: assert property (table_req.valid && !table_req.write && !fetch_stall
        |=> flash_rd_en ##1 table_done) else $error("table read timing wrong");
    chk_write_done: assert property (table_req.valid && table_req.write && !fetch_stall
        |=> table_done) else $error("table write not acknowledged");
    chk_stall_refuse: assert property (table_req.valid && fetch_stall
        |=> !flash_rd_en && !table_done) else $error("table op ran during stall");
    chk_start_stall: assert property (prog_start |-> fetch_stall)
        else $error("start without fetch stall");
    chk_block_align: assert property (prog_start && !prog_cmd.erase
        |-> prog_cmd.addr[2:0] == 3'h0) else $error("write block not aligned");
    chk_row_align: assert property (prog_start && prog_cmd.erase
        |-> prog_cmd.addr[5:0] == 6'h00) else $error("erase row not aligned");
    chk_unlock_zero: assert property (sfr_req.rd && sfr_req.addr == UNLOCK_SEQUENCE_ADDR
        |=> sfr_rdata == 8'h00) else $error("unlock register not zero");
    chk_flag_sticky: assert property (write_done_irq_flag && !write_done_irq_clear
        |=> write_done_irq_flag) else $error("done flag dropped by itself");
    chk_nop_subst: assert property (fetch_invalid |=> exec_word == NOP_WORD)
        else $error("invalid word not replaced");
endmodule : flash_table_checker

bind program_flash_table_access flash_table_checker u_chk (.sys_clk, .reset_n, .sfr_req,
    .sfr_rdata, .table_req, .table_done, .flash_rd_en, .prog_start, .prog_cmd, .fetch_stall,
    .fetch_invalid, .exec_word, .write_done_irq_flag, .write_done_irq_clear);
`default_nettype wire

// *** verification/flash_array_model.sv ***
`default_nettype none
module flash_array_model
    import flash_table_pkg::*;
(
    input wire logic sys_clk,
    input wire logic flash_rd_en,
    input wire logic [21:0] flash_rd_addr,
    output logic [7:0] flash_rd_data,
    input wire logic prog_start,
    input wire prog_cmd_t prog_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    int n_prog = 0;
    prog_cmd_t last_cmd = '0;
    logic [7:0] prev_q = 8'h00;
    // bit 21 alters content; idle bus shows the inverse of the last byte
    always_comb flash_rd_data = flash_rd_en ? {flash_rd_addr[21], flash_rd_addr[6:0]} ^ 8'h3c
        : ~prev_q;
    always @(posedge sys_clk) begin
        if (flash_rd_en) prev_q <= flash_rd_data;
        if (prog_start) begin
            n_prog <= n_prog + 1;
            last_cmd <= prog_cmd;
        end
    end
endmodule : flash_array_model
`default_nettype wire

// *** verification/program_flash_table_access_bench.sv ***
`default_nettype none
module program_flash_table_access_bench import flash_table_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    sfr_req_t sfr_req = '0;
    table_req_t table_req = '0;
    logic [15:0] fetch_word = 16'h0000;
    logic fetch_invalid = 1'b0;
    logic watchdog_reset = 1'b0;
    logic write_done_irq_clear = 1'b0;
    logic [7:0] sfr_rdata, flash_rd_data;
    logic table_done, flash_rd_en, prog_start, fetch_stall, write_done_irq_flag, eeprom_rd_start;
    logic [21:0] flash_rd_addr;
    prog_cmd_t prog_cmd;
    logic [15:0] exec_word;
    logic [63:0] exp;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    program_flash_table_access #(.PROG_CYCLES(20)) dut (.sys_clk, .reset_n, .sfr_req,
        .sfr_rdata, .table_req, .table_done, .flash_rd_en, .flash_rd_addr, .flash_rd_data,
        .prog_start, .prog_cmd, .eeprom_wr_start(), .eeprom_rd_start, .fetch_stall,
        .fetch_word, .fetch_invalid, .exec_word, .master_clear_pin_n(1'b1), .watchdog_reset,
        .write_done_irq_flag, .write_done_irq_clear);
    flash_array_model model (.sys_clk, .flash_rd_en, .flash_rd_addr, .flash_rd_data,
        .prog_start, .prog_cmd);
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] byte_at(input logic [21:0] a);
        return {a[21], a[6:0]} ^ 8'h3c;
    endfunction : byte_at
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        n_compared++;
        if (got !== want) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, want);
        end
    endtask : check
    task automatic sfr(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{wr, ~wr, a, d};
        @(posedge sys_clk);
        sfr_req <= '0;
        #1;
    endtask : sfr
    task automatic rd(input logic [11:0] a, input logic [7:0] want);
        sfr(1'b0, a, 8'h00);
        check(sfr_rdata, want);
    endtask : rd
    task automatic setp(input logic [21:0] p);
        sfr(1'b1, POINTER_LOW_ADDR, p[7:0]);
        sfr(1'b1, POINTER_HIGH_ADDR, p[15:8]);
        sfr(1'b1, POINTER_UPPER_ADDR, {2'b00, p[21:16]});
    endtask : setp
    task automatic tbl(input logic wr, input ptr_mode_t m);
        @(posedge sys_clk);
        table_req <= '{1'b1, wr, m};
        @(posedge sys_clk);
        table_req <= '0;
        repeat (2) @(posedge sys_clk);
    endtask : tbl
    task automatic start(input logic [7:0] ctl);
        // target and enable must stand before the start
        sfr(1'b1, MEMORY_CONTROL_ADDR, ctl & 8'hfd);
        sfr(1'b1, UNLOCK_SEQUENCE_ADDR, UNLOCK_FIRST);
        sfr(1'b1, UNLOCK_SEQUENCE_ADDR, UNLOCK_SECOND);
        sfr(1'b1, MEMORY_CONTROL_ADDR, ctl);
    endtask : start
    task automatic wait_idle;
        for (int i = 0; i < 100 && fetch_stall !== 1'b0; i++) @(posedge sys_clk);
        #1;
        check(fetch_stall, 1'b0);
    endtask : wait_idle
    // fetch input toggles for the no-op path; ceiling ends a hang
    always @(posedge sys_clk) begin
        cycles++;
        fetch_invalid <= ~fetch_invalid;
        fetch_word <= fetch_word + 16'h0001;
        if (cycles == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(MEMORY_CONTROL_ADDR, MEMORY_CONTROL_RESET);
        sfr(1'b1, MEMORY_CONTROL_ADDR, 8'h01);
        check(eeprom_rd_start, 1'b1);
        sfr(1'b1, UNLOCK_SEQUENCE_ADDR, UNLOCK_FIRST);
        rd(UNLOCK_SEQUENCE_ADDR, 8'h00);
        setp(22'h1ffffe);
        tbl(1'b0, PTR_POST_INC);
        rd(TABLE_LATCH_ADDR, byte_at(22'h1ffffe));
        tbl(1'b0, PTR_POST_INC);
        rd(TABLE_LATCH_ADDR, byte_at(22'h1fffff));
        tbl(1'b0, PTR_KEEP);
        rd(TABLE_LATCH_ADDR, byte_at(22'h000000));
        rd(POINTER_UPPER_ADDR, 8'h00);
        setp(22'h3fffff);
        tbl(1'b0, PTR_PRE_INC);
        rd(TABLE_LATCH_ADDR, byte_at(22'h200000));
        tbl(1'b0, PTR_POST_DEC);
        rd(POINTER_UPPER_ADDR, 8'h3f);
        rd(POINTER_LOW_ADDR, 8'hff);
        setp(22'h000123);
        for (int i = 0; i < 8; i++) begin
            sfr(1'b1, TABLE_LATCH_ADDR, 8'h10 + 8'(i));
            tbl(1'b1, PTR_POST_INC);
            exp[8 * ((3 + i) % 8) +: 8] = 8'h10 + 8'(i);
        end
        start(8'h86);
        tbl(1'b0, PTR_KEEP);
        check(model.n_prog, 1);
        check(model.last_cmd.addr, 22'h000128);
        check(model.last_cmd.data, exp);
        check(model.last_cmd.erase, 1'b0);
        wait_idle();
        check(write_done_irq_flag, 1'b1);
        rd(MEMORY_CONTROL_ADDR, 8'h84);
        @(posedge sys_clk);
        write_done_irq_clear <= 1'b1;
        @(posedge sys_clk);
        write_done_irq_clear <= 1'b0;
        #1;
        check(write_done_irq_flag, 1'b0);
        start(8'h96);
        wait_idle();
        check(model.last_cmd.erase, 1'b1);
        check(model.last_cmd.addr, 22'h000100);
        rd(MEMORY_CONTROL_ADDR, 8'h84);
        start(8'h82);
        repeat (5) @(posedge sys_clk);
        check(model.n_prog, 2);
        rd(MEMORY_CONTROL_ADDR, 8'h80);
        start(8'h86);
        @(posedge sys_clk);
        watchdog_reset <= 1'b1;
        @(posedge sys_clk);
        watchdog_reset <= 1'b0;
        wait_idle();
        rd(MEMORY_CONTROL_ADDR, 8'h88);
        wrap_up();
    end
endmodule : program_flash_table_access_bench
`default_nettype wire
